// ### src/etmc_timer.v
`timescale 1ns/1ns
`include "etmc_consts.vh"
// Function
// R01 - run 0 clears and stops; 1 counts
// R02 - mode 0 clear-on-match, 1 PWM
// R03 - set/clear field: 00 hold, 01 clear, 10 set
// R04 - set/clear ignored in PWM mode
// R05 - invert enables toggle; in PWM selects polarity
// R06 - output enable 0 forces pin low
// R07 - software configures in four ordered writes
// R08 - no other bit changes while running
// R09 - set/clear bits read back zero
// R10 - software writes zero to bits 4, 5
// R11 - PWM stop forces inactive output level
// R12 - control changes reach pin while stopped
// R13 - control register at FF6B, reset 00
// R14 - match clears counter, toggles if enabled
// R15 - PWM wraps, active until compare match
module etmc_timer #(
    parameter W   = 8,
    parameter DIV = 1
) (
    // clock, reset, clock enable
    input  wire                    clk_i,
    input  wire                    rst_b_i,
    input  wire                    ce_i,
    // register port
    input  wire [`ETMC_ADDR_W-1:0] addr_i,
    input  wire [7:0]              wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output reg  [7:0]              rdata_o,
    // timer output
    output reg                     timer_output_pin_o,
    output wire                    match_o
);
    reg  [7:0]   timer_mode_control;
    reg  [W-1:0] compare_value;
    reg          out_ff;
    reg          pwm_active;
    wire [W-1:0] counter_value;
    wire         tick;
    wire         cnt_match;
    wire         cnt_wrap;

    wire count_run_bit          = timer_mode_control[`ETMC_BIT_RUN];
    wire mode_select_bit        = timer_mode_control[`ETMC_BIT_MODE];
    wire invert_or_polarity_bit = timer_mode_control[`ETMC_BIT_INV];
    wire output_enable_bit      = timer_mode_control[`ETMC_BIT_OE];
    wire out_flipflop_set       = wdata_i[`ETMC_BIT_FF_SET];
    wire out_flipflop_clear     = wdata_i[`ETMC_BIT_FF_CLR];
    wire tmc_wr                 = wr_i && (addr_i == `ETMC_TMC_ADDR);

    assign match_o = cnt_match && tick;

    etmc_prescaler #(
        .DIV (DIV)
    ) u_pre (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .run_i   (count_run_bit),
        .tick_o  (tick)
    );

    etmc_counter #(
        .W (W)
    ) u_cnt (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .run_i   (count_run_bit),
        .tick_i  (tick),
        .pwm_i   (mode_select_bit),
        .cmp_i   (compare_value),
        .cnt_o   (counter_value),
        .match_o (cnt_match),
        .wrap_o  (cnt_wrap)
    );

    // register writes; set/clear bits are strobes and never stored
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            timer_mode_control <= `ETMC_TMC_RESET; // R13
            compare_value      <= {W{1'b0}};
        end else if (ce_i && wr_i) begin
            if (addr_i == `ETMC_TMC_ADDR) begin
                // bits 4,5 are kept zero even if software breaks the convention
                timer_mode_control <= wdata_i & `ETMC_TMC_RD_MASK; // R09 R10
            end
            if (addr_i == `ETMC_CMP_ADDR) begin
                compare_value <= wdata_i[W-1:0];
            end
        end
    end

    // output flip-flop for clear-and-start mode
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            out_ff <= 1'b0;
        end else if (ce_i) begin
            if (tmc_wr && !wdata_i[`ETMC_BIT_MODE] && (out_flipflop_set ^ out_flipflop_clear)) begin
                // a forced level beats a toggle; a plain write never eats one
                case ({out_flipflop_set, out_flipflop_clear}) // R03 R04
                    2'b01:   out_ff <= 1'b0;
                    2'b10:   out_ff <= 1'b1;
                    default: out_ff <= out_ff;
                endcase
            end else if (!mode_select_bit && count_run_bit && tick && cnt_match
                         && invert_or_polarity_bit) begin
                out_ff <= ~out_ff; // R05 R14
            end
        end
    end

    // pwm phase: active from wrap until compare match
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            pwm_active <= 1'b0;
        end else if (ce_i) begin
            if (!count_run_bit || !mode_select_bit) begin
                pwm_active <= 1'b0; // R11
            end else if (tick) begin
                if (cnt_wrap) begin
                    pwm_active <= 1'b1; // R15
                end else if (cnt_match) begin
                    pwm_active <= 1'b0; // R15
                end
            end
        end
    end

    // pin level, recomputed every cycle so stopped-state changes show too
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            timer_output_pin_o <= 1'b0;
        end else if (ce_i) begin
            if (!output_enable_bit) begin
                timer_output_pin_o <= 1'b0; // R06
            end else if (mode_select_bit) begin
                timer_output_pin_o <= pwm_active ^ invert_or_polarity_bit; // R05 R11 R12
            end else begin
                timer_output_pin_o <= out_ff; // R12
            end
        end
    end

    // read port, data one cycle after the strobe; unmapped reads zero
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (rd_i && addr_i == `ETMC_TMC_ADDR) begin
                rdata_o <= timer_mode_control & `ETMC_TMC_RD_MASK; // R09
            end else if (rd_i && addr_i == `ETMC_CMP_ADDR) begin
                rdata_o <= compare_value;
            end else if (rd_i && addr_i == `ETMC_CNT_ADDR) begin
                rdata_o <= counter_value;
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end
endmodule

// ### src/etmc_consts.vh
`ifndef ETMC_CONSTS_VH
`define ETMC_CONSTS_VH
// register map
`define ETMC_ADDR_W          16
`define ETMC_TMC_ADDR        16'hFF6B
`define ETMC_CMP_ADDR        16'hFF6C
`define ETMC_CNT_ADDR        16'hFF6D
`define ETMC_TMC_RESET       8'h00
`define ETMC_CMP_RESET       8'h00
// control field positions
`define ETMC_BIT_RUN         7
`define ETMC_BIT_MODE        6
`define ETMC_BIT_FF_SET      3
`define ETMC_BIT_FF_CLR      2
`define ETMC_BIT_INV         1
`define ETMC_BIT_OE          0
// readable bits of the control register
`define ETMC_TMC_RD_MASK     8'hC3
`endif

// ### src/etmc_counter.v
`timescale 1ns/1ns
// 8-bit up counter with clear, match and wrap flags
module etmc_counter #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_b_i,
    input  wire         ce_i,
    // control
    input  wire         run_i,
    input  wire         tick_i,
    input  wire         pwm_i,
    input  wire [W-1:0] cmp_i,
    // status
    output reg  [W-1:0] cnt_o,
    output wire         match_o,
    output wire         wrap_o
);
    assign match_o = (cnt_o == cmp_i);
    assign wrap_o  = (cnt_o == {W{1'b1}});

    // count, clear on match in clear-and-start mode, hold cleared when stopped
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_o <= {W{1'b0}};
        end else if (ce_i) begin
            if (!run_i) begin
                cnt_o <= {W{1'b0}}; // R01
            end else if (tick_i) begin
                if (!pwm_i && match_o) begin
                    cnt_o <= {W{1'b0}}; // R02 R14
                end else begin
                    cnt_o <= cnt_o + {{(W-1){1'b0}}, 1'b1}; // R15
                end
            end
        end
    end
endmodule

// ### src/etmc_prescaler.v
`timescale 1ns/1ns
// count clock enable: one tick every DIV clock cycles
module etmc_prescaler #(
    parameter DIV = 1
) (
    // clock and reset
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire ce_i,
    // control and tick
    input  wire run_i,
    output wire tick_o
);
    reg [15:0] div_cnt;

    // no tick while frozen, so match pulses never outrun the counter
    assign tick_o = ce_i && run_i && (div_cnt == DIV[15:0] - 16'h0001);

    // restart the divider whenever counting stops so phase is repeatable
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_cnt <= 16'h0000;
        end else if (ce_i) begin
            if (!run_i || tick_o) begin
                div_cnt <= 16'h0000;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end
endmodule

// ### test/etmc_asserts.sv
`timescale 1ns/1ns
`include "etmc_consts.vh"
// port-level checks; keeps its own copy of the stored control bits
module etmc_asserts (
    // clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic                    ce_i,
    // register port
    input wire logic [`ETMC_ADDR_W-1:0] addr_i,
    input wire logic [7:0]              wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire logic [7:0]              rdata_o,
    // timer output
    input wire logic                    timer_output_pin_o,
    input wire logic                    match_o
);
    logic [7:0] ctl;
    wire        tw = wr_i && ce_i && addr_i == `ETMC_TMC_ADDR;
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // shadow copy; set/clear bits never stored, so masked here too
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctl <= 8'h00;
        end else if (tw) begin
            ctl <= wdata_i & 8'hC3;
        end
    end
    // run bit low for two samples, so the counter and pwm state are idle
    sequence s_stopped;
        (!ctl[7])[*2];
    endsequence
    sequence s_ctl_rd;
        rd_i && addr_i == `ETMC_TMC_ADDR;
    endsequence
    a_rd_ctl_zero: assert property (s_ctl_rd |=> (rdata_o & 8'h3C) == 8'h00)
        else $error("control readback has write-only bits set");
    a_rd_ctl_value: assert property (tw ##1 !tw ##1 s_ctl_rd |=> rdata_o == ($past(wdata_i, 3) & 8'hC3))
        else $error("control readback differs from write");
    a_rd_unmapped: assert property (rd_i && addr_i > `ETMC_CNT_ADDR |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_oe_low: assert property (!ctl[0] |=> !timer_output_pin_o)
        else $error("pin high with output disabled");
    a_ff_force: assert property (tw && !wdata_i[6] && wdata_i[0] && (wdata_i[3] ^ wdata_i[2])
        |=> ##1 timer_output_pin_o == $past(wdata_i[3], 2))
        else $error("set or clear not seen at pin");
    a_match_runs: assert property (match_o |-> ctl[7])
        else $error("match while stopped");
    a_cnt_stop: assert property (s_stopped ##0 rd_i && addr_i == `ETMC_CNT_ADDR |=> rdata_o == 8'h00)
        else $error("counter not cleared when stopped");
    a_match_toggle: assert property (match_o && ctl[1:0] == 2'b11 && !ctl[6]
        |=> ##1 timer_output_pin_o != $past(timer_output_pin_o))
        else $error("no toggle on match");
    a_pwm_stop: assert property (s_stopped ##0 ctl[6] && ctl[0] |=> timer_output_pin_o == $past(ctl[1]))
        else $error("stopped pwm output not inactive");
    a_pwm_match: assert property (match_o && ctl[6] && ctl[0] |=> ##1 timer_output_pin_o == ctl[1])
        else $error("pwm output active after match");
endmodule

// ### test/tb_eight_bit_timer_mode_control.sv
`timescale 1ns/1ns
`include "etmc_consts.vh"
// drives the timer through its register port and watches the pin
module tb_eight_bit_timer_mode_control;
    localparam logic [15:0] tmc = `ETMC_TMC_ADDR;
    localparam logic [15:0] cmp = `ETMC_CMP_ADDR;
    localparam logic [15:0] cnt = `ETMC_CNT_ADDR;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, p;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    wire  [7:0]  rdata_o;
    wire         pin, match_o;
    int          n_mismatch = 0, n_compared = 0, k;
    etmc_timer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_output_pin_o(pin), .match_o(match_o));
    // 50 MHz
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task chk(input string n, input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, e);
    endtask
    // pin lags the register by one more edge
    task pin_is(input logic e);
        repeat (2) @(posedge clk_i);
        #1 chk("pin", {7'h00, pin}, {7'h00, e});
    endtask
    task t_regs;
        rd(tmc, 8'h00);
        rd(cmp, 8'h00);
        rd(16'hFF6E, 8'h00);
        wr(tmc, 8'h46);
        rd(tmc, 8'h42);
        $display("t_regs done");
    endtask
    // stopped clear mode: force, hold, gate
    task t_ff;
        wr(tmc, 8'h00);
        wr(tmc, 8'h01);
        wr(tmc, 8'h09);
        pin_is(1'b1);
        wr(tmc, 8'h08);
        pin_is(1'b0);
        wr(tmc, 8'h01);
        pin_is(1'b1);
        wr(tmc, 8'h05);
        pin_is(1'b0);
        $display("t_ff done");
    endtask
    task t_pwm;
        wr(tmc, 8'h40);
        wr(tmc, 8'h41);
        pin_is(1'b0);
        wr(tmc, 8'h49);
        pin_is(1'b0);
        wr(tmc, 8'h43);
        pin_is(1'b1);
        wr(cmp, 8'h80);
        wr(tmc, 8'h40);
        wr(tmc, 8'h41);
        wr(tmc, 8'hC1);
        repeat (300) @(posedge clk_i);
        k = 0;
        repeat (256) begin
            @(posedge clk_i);
            #1 k += pin;
        end
        chk("high", 8'(k), 8'h81);
        wr(tmc, 8'h41);
        pin_is(1'b0);
        rd(cnt, 8'h00);
        $display("t_pwm done");
    endtask
    // match at 3 toggles the pin every fourth cycle
    task t_clr;
        wr(cmp, 8'h03);
        wr(tmc, 8'h02);
        wr(tmc, 8'h03);
        wr(tmc, 8'h07);
        wr(tmc, 8'h83);
        repeat (8) @(posedge clk_i);
        #1 p = pin;
        k = 0;
        repeat (16) begin
            @(posedge clk_i);
            #1 k += (pin != p);
            p = pin;
        end
        chk("toggles", 8'(k), 8'h04);
        // clock enable low: the running pin must stop toggling
        @(posedge clk_i);
        ce_i <= 1'b0;
        #1 p = pin;
        k = 0;
        repeat (8) begin
            @(posedge clk_i);
            #1 k += (pin != p);
        end
        chk("frozen", 8'(k), 8'h00);
        @(posedge clk_i);
        ce_i <= 1'b1;
        wr(tmc, 8'h03);
        rd(cnt, 8'h00);
        $display("t_clr done");
    endtask
    task test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs;
        t_ff;
        t_pwm;
        t_clr;
        test_done;
    end
    // about seven times the expected run
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule
bind etmc_timer etmc_asserts u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_output_pin_o(timer_output_pin_o), .match_o(match_o));
